// ==== nisu_top.sv ====
// APB-reached execution unit for pointer increments, nibble subtract and add-with-carry.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module nisu_top (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic carryFlag,
    output logic zeroFlag
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Returns carry-out in bit 4 and the stepped nibble in bits 3 to 0.
    function automatic logic [4:0] nibbleStep(input logic [3:0] nib, input logic cin);
        nibbleStep = {1'b0, nib} + {4'h0, cin};
    endfunction

    function automatic logic knownOffset(input logic [7:0] adr);
        case (adr)
            nisu_pkg::OFS_INSTR, nisu_pkg::OFS_TABLE, nisu_pkg::OFS_INDEX,
            nisu_pkg::OFS_PSW, nisu_pkg::OFS_REGPTR, nisu_pkg::OFS_BANK,
            nisu_pkg::OFS_MEMADDR, nisu_pkg::OFS_MEMDATA, nisu_pkg::OFS_STATUS: begin
                knownOffset = 1'b1;
            end
            default: begin
                knownOffset = 1'b0;
            end
        endcase
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [3:0] dataMem [0:(1 << nisu_pkg::MEM_AW) - 1];
    logic [15:0] table_address_pointer_ff;
    logic [11:0] index_pointer_ff;
    logic [4:0] program_status_word_ff;
    logic [3:0] general_register_pointer_low_ff;
    logic [3:0] general_register_pointer_high_ff;
    logic bank_ff;
    logic [7:0] memAddr_ff;
    logic [15:0] lastInstr_ff;
    logic [7:0] lastEffAddr_ff;
    logic unsupported_ff;
    logic [15:0] execCount_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;

    logic [15:0] nxt_table;
    logic [11:0] nxt_index;
    logic [4:0] nxt_psw;
    logic [31:0] nxt_prdata;
    logic [3:0] rippleNib;
    logic rippleCarry;
    logic [4:0] stepOut;
    logic [4:0] idxStep;
    logic idxCarry;
    nisu_pkg::nisu_exec_t execKind;
    logic [6:0] operandAddr;
    logic [7:0] effAddr;
    logic [7:0] genRegAddr;
    logic [15:0] instrWord;
    logic busTake;
    logic busWrite;
    logic instrWrite;
    logic compare_flag;
    logic index_enable_flag;
    logic storeResult;

    nisu_alu_if aluBus ();

    nisu_nibble_alu alu (
        .bus(aluBus)
    );

    // ----------------------------------------
    // APB slave handshake
    // ----------------------------------------
    // One wait state: pready rises in the second access cycle, so every answer is registered.
    assign busTake = psel & penable & pready_ff;
    assign busWrite = busTake & pwrite;
    assign instrWrite = busWrite & (paddr == nisu_pkg::OFS_INSTR);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= psel & penable & ~pready_ff;
            pslverr_ff <= psel & penable & ~pready_ff & ~knownOffset(paddr);
        end
    end

    // ----------------------------------------
    // Decode and operand addressing
    // ----------------------------------------
    assign instrWord = pwdata[15:0];
    assign compare_flag = program_status_word_ff[nisu_pkg::PSW_COMPARE];
    assign index_enable_flag = program_status_word_ff[nisu_pkg::PSW_INDEX_EN];
    assign operandAddr = instrWord[10:4];

    always_comb begin
        case (instrWord[15:11])
            nisu_pkg::OP_SYS: begin
                if (instrWord[10:8] == nisu_pkg::SYS_HI && instrWord[3:0] == nisu_pkg::SYS_LO
                    && instrWord[7:4] == nisu_pkg::SYS_INC_TABLE) begin
                    execKind = nisu_pkg::EX_INC_TABLE;
                end else if (instrWord[10:8] == nisu_pkg::SYS_HI && instrWord[3:0] == nisu_pkg::SYS_LO
                    && instrWord[7:4] == nisu_pkg::SYS_INC_INDEX) begin
                    execKind = nisu_pkg::EX_INC_INDEX;
                end else begin
                    execKind = nisu_pkg::EX_UNSUP;
                end
            end
            nisu_pkg::OP_SUB: begin
                execKind = nisu_pkg::EX_SUB;
            end
            nisu_pkg::OP_ADD_WITH_CARRY_INSTRUCTION_IMM: begin
                execKind = nisu_pkg::EX_ADD_WITH_CARRY_INSTRUCTION_IMM;
            end
            default: begin
                execKind = nisu_pkg::EX_UNSUP;
            end
        endcase
        if (!instrWrite) begin
            execKind = nisu_pkg::EX_NONE;
        end
    end

    always_comb begin
        effAddr = {bank_ff, operandAddr};
        if (index_enable_flag) begin
            effAddr = {bank_ff, operandAddr} | index_pointer_ff[7:0];
        end
        // Row is the high pointer's low bit and the low pointer's top three bits.
        genRegAddr = {general_register_pointer_high_ff[0], general_register_pointer_low_ff[3:1],
                      instrWord[3:0]};
    end

    // ----------------------------------------
    // Arithmetic hookup
    // ----------------------------------------
    always_comb begin
        aluBus.decimal = program_status_word_ff[nisu_pkg::PSW_DECIMAL];
        if (execKind == nisu_pkg::EX_ADD_WITH_CARRY_INSTRUCTION_IMM) begin
            aluBus.opA = dataMem[effAddr];
            aluBus.opB = instrWord[3:0];
            aluBus.carryIn = program_status_word_ff[nisu_pkg::PSW_CARRY];
            aluBus.subtract = 1'b0;
        end else begin
            aluBus.opA = dataMem[genRegAddr];
            aluBus.opB = dataMem[effAddr];
            aluBus.carryIn = 1'b0;
            aluBus.subtract = 1'b1;
        end
    end

    assign storeResult = ~compare_flag;

    // ----------------------------------------
    // Pointer increments
    // ----------------------------------------
    always_comb begin
        nxt_table = table_address_pointer_ff;
        rippleCarry = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rippleNib = table_address_pointer_ff[i * 4 +: 4];
            stepOut = nibbleStep(rippleNib, rippleCarry);
            nxt_table[i * 4 +: 4] = stepOut[3:0];
            rippleCarry = stepOut[4];
        end
        // The upper six bits are not built; forcing them here keeps them zero after an increment.
        nxt_table[15:nisu_pkg::TABLE_USED] = '0;
    end

    // The index ripple keeps its own step and carry so it shares no variable with the table ripple.
    always_comb begin
        nxt_index = index_pointer_ff;
        idxCarry = 1'b1;
        for (int j = 0; j < 3; j++) begin
            idxStep = nibbleStep(index_pointer_ff[j * 4 +: 4], idxCarry);
            nxt_index[j * 4 +: 4] = idxStep[3:0];
            idxCarry = idxStep[4];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            table_address_pointer_ff <= nisu_pkg::TABLE_RST;
        end else if (execKind == nisu_pkg::EX_INC_TABLE) begin
            table_address_pointer_ff <= nxt_table;
        end else if (busWrite && paddr == nisu_pkg::OFS_TABLE) begin
            table_address_pointer_ff <= {6'h00, pwdata[nisu_pkg::TABLE_USED - 1:0]};
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            index_pointer_ff <= nisu_pkg::INDEX_RST;
        end else if (execKind == nisu_pkg::EX_INC_INDEX) begin
            index_pointer_ff <= nxt_index;
        end else if (busWrite && paddr == nisu_pkg::OFS_INDEX) begin
            index_pointer_ff <= pwdata[11:0];
        end
    end

    // ----------------------------------------
    // Flags
    // ----------------------------------------
    always_comb begin
        nxt_psw = program_status_word_ff;
        if (execKind == nisu_pkg::EX_SUB || execKind == nisu_pkg::EX_ADD_WITH_CARRY_INSTRUCTION_IMM) begin
            nxt_psw[nisu_pkg::PSW_CARRY] = aluBus.carryOut;
            if (aluBus.result != 4'h0) begin
                nxt_psw[nisu_pkg::PSW_ZERO] = 1'b0;
            end else if (!compare_flag) begin
                nxt_psw[nisu_pkg::PSW_ZERO] = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            program_status_word_ff <= nisu_pkg::PSW_RST;
        end else if (busWrite && paddr == nisu_pkg::OFS_PSW) begin
            program_status_word_ff <= pwdata[4:0];
        end else begin
            program_status_word_ff <= nxt_psw;
        end
    end

    // ----------------------------------------
    // Data memory
    // ----------------------------------------
    // The array has no reset; software must clear it before relying on its contents.
    always_ff @(posedge clock) begin
        if (execKind == nisu_pkg::EX_SUB && storeResult) begin
            dataMem[genRegAddr] <= aluBus.result;
        end else if (execKind == nisu_pkg::EX_ADD_WITH_CARRY_INSTRUCTION_IMM && storeResult) begin
            dataMem[effAddr] <= aluBus.result;
        end else if (busWrite && paddr == nisu_pkg::OFS_MEMDATA) begin
            dataMem[memAddr_ff] <= pwdata[3:0];
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            general_register_pointer_low_ff <= nisu_pkg::REGPTR_RST[3:0];
            general_register_pointer_high_ff <= nisu_pkg::REGPTR_RST[7:4];
        end else if (busWrite && paddr == nisu_pkg::OFS_REGPTR) begin
            general_register_pointer_low_ff <= pwdata[3:0];
            general_register_pointer_high_ff <= pwdata[7:4];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bank_ff <= 1'b0;
            memAddr_ff <= 8'h00;
        end else if (busWrite) begin
            if (paddr == nisu_pkg::OFS_BANK) begin
                bank_ff <= pwdata[0];
            end
            if (paddr == nisu_pkg::OFS_MEMADDR) begin
                memAddr_ff <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // Execution status
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lastInstr_ff <= 16'h0000;
            lastEffAddr_ff <= 8'h00;
            execCount_ff <= 16'h0000;
        end else if (instrWrite) begin
            lastInstr_ff <= instrWord;
            lastEffAddr_ff <= effAddr;
            execCount_ff <= execCount_ff + 16'h0001;
        end
    end

    // An unknown word sets the sticky bit; a set in the clearing cycle wins.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            unsupported_ff <= 1'b0;
        end else if (execKind == nisu_pkg::EX_UNSUP) begin
            unsupported_ff <= 1'b1;
        end else if (busWrite && paddr == nisu_pkg::OFS_STATUS && pwdata[nisu_pkg::STAT_UNSUP]) begin
            unsupported_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        case (paddr)
            nisu_pkg::OFS_INSTR: begin
                nxt_prdata[15:0] = lastInstr_ff;
            end
            nisu_pkg::OFS_TABLE: begin
                nxt_prdata[15:0] = table_address_pointer_ff;
            end
            nisu_pkg::OFS_INDEX: begin
                nxt_prdata[11:0] = index_pointer_ff;
            end
            nisu_pkg::OFS_PSW: begin
                nxt_prdata[4:0] = program_status_word_ff;
            end
            nisu_pkg::OFS_REGPTR: begin
                nxt_prdata[7:0] = {general_register_pointer_high_ff, general_register_pointer_low_ff};
            end
            nisu_pkg::OFS_BANK: begin
                nxt_prdata[0] = bank_ff;
            end
            nisu_pkg::OFS_MEMADDR: begin
                nxt_prdata[7:0] = memAddr_ff;
            end
            nisu_pkg::OFS_MEMDATA: begin
                nxt_prdata[3:0] = dataMem[memAddr_ff];
            end
            nisu_pkg::OFS_STATUS: begin
                nxt_prdata[7:0] = lastEffAddr_ff;
                nxt_prdata[nisu_pkg::STAT_UNSUP] = unsupported_ff;
                nxt_prdata[31:16] = execCount_ff;
            end
            default: begin
                nxt_prdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && penable && !pready_ff && !pwrite) begin
            prdata_ff <= nxt_prdata;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign carryFlag = program_status_word_ff[nisu_pkg::PSW_CARRY];
    assign zeroFlag = program_status_word_ff[nisu_pkg::PSW_ZERO];
endmodule // nisu_top
`default_nettype wire

// ==== nisu_pkg.sv ====
// Constants shared by the nibble increment and subtract unit.
`default_nettype none
package nisu_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_TABLE = 8'h04;
    localparam logic [7:0] OFS_INDEX = 8'h08;
    localparam logic [7:0] OFS_PSW = 8'h0c;
    localparam logic [7:0] OFS_REGPTR = 8'h10;
    localparam logic [7:0] OFS_BANK = 8'h14;
    localparam logic [7:0] OFS_MEMADDR = 8'h18;
    localparam logic [7:0] OFS_MEMDATA = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    // ----------------------------------------
    // Program status word and status register bit positions
    // ----------------------------------------
    localparam int PSW_CARRY = 0;
    localparam int PSW_ZERO = 1;
    localparam int PSW_COMPARE = 2;
    localparam int PSW_DECIMAL = 3;
    localparam int PSW_INDEX_EN = 4;
    localparam int STAT_UNSUP = 8;
    // ----------------------------------------
    // Widths and reset values
    // ----------------------------------------
    localparam int TABLE_USED = 10;
    localparam int MEM_AW = 8;
    localparam logic [15:0] TABLE_RST = 16'h0000;
    localparam logic [11:0] INDEX_RST = 12'h000;
    localparam logic [4:0] PSW_RST = 5'h00;
    localparam logic [7:0] REGPTR_RST = 8'h00;
    // ----------------------------------------
    // Instruction fields and codes, decimal constants and execution kinds
    // ----------------------------------------
    localparam logic [4:0] OP_SYS = 5'h07;
    localparam logic [4:0] OP_SUB = 5'h01;
    localparam logic [4:0] OP_ADD_WITH_CARRY_INSTRUCTION_IMM = 5'h12;
    localparam logic [2:0] SYS_HI = 3'h0;
    localparam logic [3:0] SYS_INC_TABLE = 4'h9;
    localparam logic [3:0] SYS_INC_INDEX = 4'h8;
    localparam logic [3:0] SYS_LO = 4'h0;
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [3:0] BCD_ADJ = 4'h6;
    localparam logic [3:0] BCD_TEN = 4'ha;
    typedef enum logic [2:0] {
        EX_NONE = 3'b000,
        EX_INC_TABLE = 3'b001,
        EX_INC_INDEX = 3'b010,
        EX_SUB = 3'b011,
        EX_ADD_WITH_CARRY_INSTRUCTION_IMM = 3'b100,
        EX_UNSUP = 3'b101
    } nisu_exec_t;
endpackage
`default_nettype wire

// ==== nisu_alu_if.sv ====
// Operand and result bundle between the unit and its nibble arithmetic.
`timescale 1ns/10ps
`default_nettype none
interface nisu_alu_if;
    logic [3:0] opA;
    logic [3:0] opB;
    logic carryIn;
    logic decimal;
    logic subtract;
    logic [3:0] result;
    logic carryOut;
    modport user (output opA, output opB, output carryIn, output decimal, output subtract,
                  input result, input carryOut);
    modport alu (input opA, input opB, input carryIn, input decimal, input subtract,
                 output result, output carryOut);
endinterface
`default_nettype wire

// ==== nisu_nibble_alu.sv ====
// Combinational nibble adder and subtractor with binary and decimal modes.
`timescale 1ns/10ps
`default_nettype none
module nisu_nibble_alu (
    nisu_alu_if.alu bus
);
    logic [4:0] raw;
    logic [3:0] adj;
    logic flag;
    always_comb begin
        if (bus.subtract) begin
            raw = {1'b0, bus.opA} - {1'b0, bus.opB} - {4'h0, bus.carryIn};
        end else begin
            raw = {1'b0, bus.opA} + {1'b0, bus.opB} + {4'h0, bus.carryIn};
        end
        adj = raw[3:0];
        flag = raw[4];
        if (bus.decimal) begin
            if (bus.subtract) begin
                // A borrow wraps to sixteen, so ten is added back to land in decimal range.
                if (flag) begin
                    adj = raw[3:0] + nisu_pkg::BCD_TEN;
                end
                if (adj > nisu_pkg::BCD_MAX) begin
                    adj = adj - nisu_pkg::BCD_TEN;
                end
            end else if (raw > {1'b0, nisu_pkg::BCD_MAX}) begin
                adj = raw[3:0] + nisu_pkg::BCD_ADJ;
                flag = 1'b1;
            end
        end
        bus.result = adj;
        bus.carryOut = flag;
    end
endmodule // nisu_nibble_alu
`default_nettype wire

// ==== nisu_monitor.sv ====
// Concurrent checks on the ports of the nibble increment and subtract unit.
`timescale 1ns/10ps
`default_nettype none
module nisu_monitor (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic carryFlag,
    input wire logic zeroFlag
);
    // ----------------------------------------
    // Bus and flag properties
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    logic wrDone;
    assign wrDone = psel && penable && pready && pwrite;
    a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_ready_qual: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    a_err_unmapped: assert property (pready && (paddr > nisu_pkg::OFS_STATUS || paddr[1:0] != 2'b00) |-> pslverr)
        else $error("unmapped access without pslverr");
    a_err_mapped: assert property (pready && paddr <= nisu_pkg::OFS_STATUS && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access with pslverr");
    a_err_rdzero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_table_high: assert property (pready && !pwrite && paddr == nisu_pkg::OFS_TABLE |-> prdata[31:10] == 22'h0)
        else $error("table pointer upper bits not zero");
    a_index_high: assert property (pready && !pwrite && paddr == nisu_pkg::OFS_INDEX |-> prdata[31:12] == 20'h0)
        else $error("index pointer wider than twelve bits");
    // Flags may only move after an executed instruction or a status word write.
    a_flags_cause: assert property ($changed({carryFlag, zeroFlag}) |->
        $past(wrDone && (paddr == nisu_pkg::OFS_INSTR || paddr == nisu_pkg::OFS_PSW)))
        else $error("flags changed without a cause");
endmodule // nisu_monitor
bind nisu_top nisu_monitor i_mon (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .carryFlag(carryFlag), .zeroFlag(zeroFlag));
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the nibble increment and subtract unit.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, carryFlag, zeroFlag, errSeen;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    int failures;
    int totalChecks;
    nisu_top i_dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .carryFlag(carryFlag), .zeroFlag(zeroFlag));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic stop_test;
        $display("checks %0d failures %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // The request is held until pready is sampled high, so slow answers are tolerated.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            $display("ERROR %0t: no pready", $time);
            stop_test();
        end
        rdData = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check(rdData, exp);
    endtask
    task automatic memw(input logic [7:0] addr, input logic [3:0] val);
        apb(1'b1, nisu_pkg::OFS_MEMADDR, {24'h0, addr});
        apb(1'b1, nisu_pkg::OFS_MEMDATA, {28'h0, val});
    endtask
    task automatic memc(input logic [7:0] addr, input logic [3:0] exp);
        apb(1'b1, nisu_pkg::OFS_MEMADDR, {24'h0, addr});
        rdc(nisu_pkg::OFS_MEMDATA, {28'h0, exp});
    endtask
    task automatic exec(input logic [15:0] word);
        apb(1'b1, nisu_pkg::OFS_INSTR, {16'h0, word});
    endtask
    task automatic flags(input logic ec, input logic ez);
        @(negedge clock);
        check({31'h0, carryFlag}, {31'h0, ec});
        check({31'h0, zeroFlag}, {31'h0, ez});
    endtask
    // Register operand 3 of row 2 is 0x23, memory operand is 0x2f.
    task automatic subc(input logic [4:0] psw, input logic [3:0] rv, input logic [3:0] mv,
        input logic [3:0] er, input logic ec, input logic ez);
        memw(8'h23, rv);
        memw(8'h2f, mv);
        apb(1'b1, nisu_pkg::OFS_PSW, {27'h0, psw});
        exec({nisu_pkg::OP_SUB, 7'h2f, 4'h3});
        flags(ec, ez);
        memc(8'h23, er);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        failures = 0;
        totalChecks = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        rdc(nisu_pkg::OFS_TABLE, 32'h0);
        rdc(nisu_pkg::OFS_INDEX, 32'h0);
        rdc(nisu_pkg::OFS_PSW, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, errSeen}, 32'h1);
        $display("test reset done");
        apb(1'b1, nisu_pkg::OFS_TABLE, 32'hffff);
        rdc(nisu_pkg::OFS_TABLE, 32'h3ff);
        exec(16'h3890);
        rdc(nisu_pkg::OFS_TABLE, 32'h0);
        apb(1'b1, nisu_pkg::OFS_TABLE, 32'h0ff);
        exec(16'h3890);
        rdc(nisu_pkg::OFS_TABLE, 32'h100);
        apb(1'b1, nisu_pkg::OFS_INDEX, 32'h0ff);
        exec(16'h3880);
        rdc(nisu_pkg::OFS_INDEX, 32'h100);
        apb(1'b1, nisu_pkg::OFS_INDEX, 32'hfff);
        exec(16'h3880);
        rdc(nisu_pkg::OFS_INDEX, 32'h0);
        $display("test pointers done");
        apb(1'b1, nisu_pkg::OFS_REGPTR, 32'h04);
        apb(1'b1, nisu_pkg::OFS_BANK, 32'h0);
        subc(5'h01, 4'h7, 4'h3, 4'h4, 1'b0, 1'b0);
        subc(5'h02, 4'h3, 4'h7, 4'hc, 1'b1, 1'b0);
        subc(5'h01, 4'h5, 4'h5, 4'h0, 1'b0, 1'b1);
        subc(5'h04, 4'h5, 4'h5, 4'h5, 1'b0, 1'b0);
        subc(5'h06, 4'h5, 4'h5, 4'h5, 1'b0, 1'b1);
        subc(5'h06, 4'h3, 4'h7, 4'h3, 1'b1, 1'b0);
        subc(5'h08, 4'h3, 4'h7, 4'h6, 1'b1, 1'b0);
        subc(5'h09, 4'h9, 4'h2, 4'h7, 1'b0, 1'b0);
        $display("test subtract done");
        apb(1'b1, nisu_pkg::OFS_INDEX, 32'h40);
        memw(8'h6f, 4'h2);
        subc(5'h10, 4'h7, 4'h9, 4'h5, 1'b0, 1'b0);
        $display("test index done");
        apb(1'b1, nisu_pkg::OFS_PSW, 32'h01);
        memw(8'h10, 4'h9);
        exec({nisu_pkg::OP_ADD_WITH_CARRY_INSTRUCTION_IMM, 7'h10, 4'h3});
        flags(1'b0, 1'b0);
        memc(8'h10, 4'hd);
        apb(1'b1, nisu_pkg::OFS_PSW, 32'h05);
        exec({nisu_pkg::OP_ADD_WITH_CARRY_INSTRUCTION_IMM, 7'h10, 4'h3});
        flags(1'b1, 1'b0);
        memc(8'h10, 4'hd);
        memw(8'h10, 4'h8);
        apb(1'b1, nisu_pkg::OFS_PSW, 32'h08);
        exec({nisu_pkg::OP_ADD_WITH_CARRY_INSTRUCTION_IMM, 7'h10, 4'h3});
        flags(1'b1, 1'b0);
        memc(8'h10, 4'h1);
        exec(16'hffff);
        rdc(nisu_pkg::OFS_INSTR, 32'h0000ffff);
        apb(1'b0, nisu_pkg::OFS_STATUS, 32'h0);
        check({31'h0, rdData[8]}, 32'h1);
        apb(1'b1, nisu_pkg::OFS_STATUS, 32'h100);
        apb(1'b0, nisu_pkg::OFS_STATUS, 32'h0);
        check({31'h0, rdData[8]}, 32'h0);
        $display("test add and unsupported done");
        stop_test();
    end
endmodule // tb
`default_nettype wire
